//--- monitor_pkg.sv
// Constants and types shared by the transceiver monitor and alarm block
//
// Function
// - Both delta-sigma outputs float (no drive) from power-up.
// - After the init delay both outputs drive the stored initial code.
// - Table codes load after temperature, and above-threshold supply if enabled.
// - One quick-trip comparator is shared, polling both loss comparisons in turn.
// - Each comparator sample sets or clears that channel's trip flag.
// - A trip flag stays set until a later sample shows it cleared.
// - A receiver trips when its power is below its low threshold.
// - Fault and loss outputs assert only for enabled conditions.
// - Either receiver trip may drive the receive loss output.
// - One converter digitizes four channels round-robin through a multiplexer.
// - Each channel adds a programmable offset; power channels scale range.
// - Received-power results right-shift up to 7 bits before compare and read.
// - A shift of n divides the result by two to the n.
// - Every result is compared to high/low alarm and warning thresholds.
// - Masks keep alarms off the fault output; flags still update.
// - Temperature is signed 16-bit; offset sums wrap between 7FFF and 8000, no clamp.
// - Supply and power are unsigned 16-bit: 0000 to FFF8.
// - Outputs enable about 20 ms after power-on reset release.
// - One full pass over four channels takes 45 ms typical, 75 max.
// - Each received-power channel has its own 3-bit shift count.
package monitor_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 25_000_000;
  localparam int INIT_DELAY_MS   = 20;
  localparam int INIT_CYCLES     = CLK_HZ / 1000 * INIT_DELAY_MS;
  localparam int PASS_TIME_MS    = 45;
  localparam int SLOT_CYCLES     = CLK_HZ / 1000 * PASS_TIME_MS / 4;
  localparam int QT_SAMPLE_NS    = 12_800;
  localparam int QT_CYCLES       = QT_SAMPLE_NS / 40;

  // ----------------------------------------------------------------
  // Channels and widths
  // ----------------------------------------------------------------
  localparam int NUM_CH          = 4;
  localparam int RES_W           = 16;
  localparam int SHIFT_W         = 3;
  localparam int CODE_W          = 10;
  localparam logic [RES_W-1:0] UNSIGNED_MAX = 16'hFFF8;
  localparam logic [RES_W-1:0] SIGNED_MAX   = 16'h7FFF;
  localparam logic [RES_W-1:0] SIGNED_MIN   = 16'h8000;
  localparam logic [RES_W-1:0] ZERO_RES     = 16'h0000;

  typedef enum logic [1:0] {
    CH_TEMP,
    CH_SUPPLY,
    CH_RX_ONE,
    CH_RX_TWO
  } channel_e;

  // Limits of one channel
  typedef struct packed {
    logic [RES_W-1:0] hi_alarm;
    logic [RES_W-1:0] hi_warn;
    logic [RES_W-1:0] lo_warn;
    logic [RES_W-1:0] lo_alarm;
  } limits_s;

  // Flags of one channel
  typedef struct packed {
    logic hi_alarm;
    logic hi_warn;
    logic lo_warn;
    logic lo_alarm;
  } flags_s;

endpackage

//--- threshold_check.sv
// Threshold comparison of one conversion result
`timescale 1ns/100ps
module threshold_check
  import monitor_pkg::*;
(
  input  wire logic [RES_W-1:0] result,
  input  wire logic             is_signed,
  input  wire limits_s          limits,
  output flags_s                flags
);

  function automatic logic above(input logic [RES_W-1:0] a,
                                 input logic [RES_W-1:0] b,
                                 input logic             sgn);
    if (sgn)
      above = $signed(a) > $signed(b);
    else
      above = a > b;
  endfunction

  // Compare result against each threshold
  always_comb begin
    flags.hi_alarm = above(result, limits.hi_alarm, is_signed);
    flags.hi_warn  = above(result, limits.hi_warn, is_signed);
    flags.lo_warn  = above(limits.lo_warn, result, is_signed);
    flags.lo_alarm = above(limits.lo_alarm, result, is_signed);
  end

endmodule

//--- transceiver_monitor_alarm.sv
// Monitor sequencing, alarm flags and output control
`timescale 1ns/100ps
module transceiver_monitor_alarm
  import monitor_pkg::*;
#(
  parameter int INIT_CNT = INIT_CYCLES,
  parameter int SLOT_CNT = SLOT_CYCLES,
  parameter int QT_CNT   = QT_CYCLES
)(
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  // Converter
  output logic [1:0]                         adc_select,
  output logic                               adc_start,
  input  wire logic                          adc_done,
  input  wire logic [RES_W-1:0]              adc_raw,
  // Calibration
  input  wire logic [NUM_CH*RES_W-1:0]       ch_offset,
  input  wire logic [2*RES_W-1:0]            rx_scale,
  input  wire logic [RES_W-1:0]              supply_scale,
  input  wire logic [SHIFT_W-1:0]            rx_one_shift,
  input  wire logic [SHIFT_W-1:0]            rx_two_shift,
  // Thresholds, enables and masks
  input  wire limits_s [NUM_CH-1:0]          ch_limits,
  input  wire flags_s  [NUM_CH-1:0]          fault_enable,
  input  wire flags_s  [NUM_CH-1:0]          fault_mask,
  input  wire logic                          supply_low_enable,
  // Quick trip
  input  wire logic                          quick_trip_cmp,
  output logic                               quick_trip_sel,
  input  wire logic [1:0]                    loss_enable,
  // Delta-sigma
  input  wire logic [2*CODE_W-1:0]           init_code,
  input  wire logic [2*CODE_W-1:0]           table_code,
  output logic [2*CODE_W-1:0]                delta_sigma_code,
  output logic                               delta_sigma_out_one_oe,
  output logic                               delta_sigma_out_two_oe,
  // Results and flags
  output logic [NUM_CH*RES_W-1:0]            ch_result,
  output flags_s [NUM_CH-1:0]                ch_flags,
  output logic                               rx_one_low_power_trip,
  output logic                               rx_two_low_power_trip,
  output logic                               fault_out,
  output logic                               rx_signal_loss_out
);

  // Refuse counts too short for the synchroniser and the start pulse
  if (INIT_CNT < 1 || SLOT_CNT < 4 || QT_CNT < 4) begin
    $error("transceiver_monitor_alarm: counts too small");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic qt_meta_r;
  logic qt_sync_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      qt_meta_r <= 1'b0;
      qt_sync_r <= 1'b0;
    end else begin
      qt_meta_r <= quick_trip_cmp;
      qt_sync_r <= qt_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Power-up delay
  // ----------------------------------------------------------------
  logic [$clog2(INIT_CNT+1)-1:0] init_cnt_r;
  logic                          init_done_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      init_cnt_r  <= '0;
      init_done_r <= 1'b0;
    end else if (!init_done_r) begin
      if (init_cnt_r == $bits(init_cnt_r)'(INIT_CNT - 1))
        init_done_r <= 1'b1;
      init_cnt_r <= init_cnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Round-robin converter sequence
  // ----------------------------------------------------------------
  function automatic channel_e next_channel(input channel_e ch);
    case (ch)
      CH_TEMP:   next_channel = CH_SUPPLY;
      CH_SUPPLY: next_channel = CH_RX_ONE;
      CH_RX_ONE: next_channel = CH_RX_TWO;
      CH_RX_TWO: next_channel = CH_TEMP;
      default:   next_channel = CH_TEMP;
    endcase
  endfunction

  logic [$clog2(SLOT_CNT+1)-1:0] slot_cnt_r;
  logic                          slot_end;
  channel_e                      ch_r;
  logic                          busy_r;
  logic                          conv_done;

  // Slot boundary paces the converter
  assign slot_end  = (slot_cnt_r == $bits(slot_cnt_r)'(SLOT_CNT - 1));
  // A done pulse counts only while a conversion is outstanding
  assign conv_done = busy_r && adc_done;

  always_ff @(posedge clk) begin
    if (!rst_b)
      slot_cnt_r <= '0;
    else if (slot_end)
      slot_cnt_r <= '0;
    else
      slot_cnt_r <= slot_cnt_r + 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      adc_start <= 1'b0;
    else
      adc_start <= slot_end && !busy_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      busy_r <= 1'b0;
    else if (slot_end && !busy_r)
      busy_r <= 1'b1;
    else if (conv_done)
      busy_r <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      ch_r <= CH_TEMP;
    else if (conv_done)
      ch_r <= next_channel(ch_r);
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      adc_select <= 2'h0;
    else
      adc_select <= ch_r;
  end

  // ----------------------------------------------------------------
  // Calibration: scale, offset, right shift
  // ----------------------------------------------------------------
  function automatic logic [RES_W-1:0] sat_add(input logic [RES_W:0] s,
                                               input logic sgn);
    sat_add = s[RES_W-1:0];
    if (!sgn && s[RES_W])
      sat_add = UNSIGNED_MAX;
    if (!sgn && s[RES_W-1:0] > UNSIGNED_MAX)
      sat_add = UNSIGNED_MAX;
  endfunction

  logic [RES_W-1:0]   cal_scale;
  logic [2*RES_W-1:0] scaled;
  logic [RES_W-1:0]   scaled_hi;
  logic [RES_W-1:0]   offs;
  logic [RES_W-1:0]   cal_sum;
  logic [SHIFT_W-1:0] shift_n;
  logic [RES_W-1:0]   cal_res;
  logic               cal_signed;

  always_comb begin
    cal_signed = (ch_r == CH_TEMP);
    case (ch_r)
      CH_SUPPLY: cal_scale = supply_scale;
      CH_RX_ONE: cal_scale = rx_scale[RES_W-1:0];
      CH_RX_TWO: cal_scale = rx_scale[2*RES_W-1:RES_W];
      default:   cal_scale = 16'hFFFF;
    endcase
    case (ch_r)
      CH_RX_ONE: shift_n = rx_one_shift;
      CH_RX_TWO: shift_n = rx_two_shift;
      default:   shift_n = 3'h0;
    endcase
    scaled    = (ch_r == CH_TEMP) ? {adc_raw, 16'h0000}
                                  : adc_raw * cal_scale;
    scaled_hi = scaled[2*RES_W-1:RES_W];
    offs      = ch_offset[ch_r*RES_W +: RES_W];
    if (cal_signed)
      cal_sum = scaled_hi + offs;
    else
      cal_sum = sat_add({1'b0, scaled_hi} + {1'b0, offs}, 1'b0);
    cal_res = cal_sum >> shift_n;
  end

  // ----------------------------------------------------------------
  // Results and threshold flags
  // ----------------------------------------------------------------
  flags_s cmp_flags;

  threshold_check u_check (
    .result    (cal_res),
    .is_signed (cal_signed),
    .limits    (ch_limits[ch_r]),
    .flags     (cmp_flags)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ch_result <= '0;
      ch_flags  <= '0;
    end else if (conv_done) begin
      ch_result[ch_r*RES_W +: RES_W] <= cal_res;
      ch_flags[ch_r]                 <= cmp_flags;
    end
  end

  // Enabled, unmasked flags reach the fault output, flags themselves unmasked
  always_ff @(posedge clk) begin
    if (!rst_b)
      fault_out <= 1'b0;
    else
      fault_out <= init_done_r &&
                   |(ch_flags & fault_enable & ~fault_mask);
  end

  // ----------------------------------------------------------------
  // Shared quick-trip comparator
  // ----------------------------------------------------------------
  logic [$clog2(QT_CNT+1)-1:0] qt_cnt_r;
  logic                        qt_sample;

  // Sample instant at the end of each comparison window
  assign qt_sample = (qt_cnt_r == $bits(qt_cnt_r)'(QT_CNT - 1));

  always_ff @(posedge clk) begin
    if (!rst_b)
      qt_cnt_r <= '0;
    else if (qt_sample)
      qt_cnt_r <= '0;
    else
      qt_cnt_r <= qt_cnt_r + 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      quick_trip_sel <= 1'b0;
    else if (qt_sample)
      quick_trip_sel <= ~quick_trip_sel;
  end

  // Comparator high means power below the low threshold
  always_ff @(posedge clk) begin
    if (!rst_b)
      rx_one_low_power_trip <= 1'b0;
    else if (qt_sample && !quick_trip_sel)
      rx_one_low_power_trip <= qt_sync_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      rx_two_low_power_trip <= 1'b0;
    else if (qt_sample && quick_trip_sel)
      rx_two_low_power_trip <= qt_sync_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      rx_signal_loss_out <= 1'b0;
    else
      rx_signal_loss_out <= init_done_r &&
        ((loss_enable[0] && rx_one_low_power_trip) ||
         (loss_enable[1] && rx_two_low_power_trip));
  end

  // ----------------------------------------------------------------
  // Delta-sigma output sequencing
  // ----------------------------------------------------------------
  logic temp_seen_r;
  logic supply_ok_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      temp_seen_r <= 1'b0;
      supply_ok_r <= 1'b0;
    end else if (init_done_r && conv_done) begin
      if (ch_r == CH_TEMP)
        temp_seen_r <= 1'b1;
      if (ch_r == CH_SUPPLY && temp_seen_r)
        supply_ok_r <= !cmp_flags.lo_alarm;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      delta_sigma_out_one_oe <= 1'b0;
      delta_sigma_out_two_oe <= 1'b0;
    end else if (init_done_r) begin
      delta_sigma_out_one_oe <= 1'b1;
      delta_sigma_out_two_oe <= 1'b1;
    end
  end

  // Stored code until temperature and, if gated, supply are known good
  always_ff @(posedge clk) begin
    if (!rst_b)
      delta_sigma_code <= '0;
    else if (init_done_r && temp_seen_r &&
             (!supply_low_enable || supply_ok_r))
      delta_sigma_code <= table_code;
    else if (init_done_r)
      delta_sigma_code <= init_code;
  end

endmodule

//--- monitor_alarm_checker_sva.sv
// Assertion checker for the monitor and alarm block
`timescale 1ns/100ps
module monitor_alarm_checker
  import monitor_pkg::*;
#(
  parameter int INIT_CNT = INIT_CYCLES
)(
  input wire logic                      clk,
  input wire logic                      rst_b,
  input wire logic [1:0]                adc_select,
  input wire logic                      adc_start,
  input wire logic                      adc_done,
  input wire logic [NUM_CH*RES_W-1:0]   ch_result,
  input wire flags_s [NUM_CH-1:0]       ch_flags,
  input wire flags_s [NUM_CH-1:0]       fault_enable,
  input wire flags_s [NUM_CH-1:0]       fault_mask,
  input wire logic                      quick_trip_sel,
  input wire logic [1:0]                loss_enable,
  input wire logic                      delta_sigma_out_one_oe,
  input wire logic                      delta_sigma_out_two_oe,
  input wire logic                      rx_one_low_power_trip,
  input wire logic                      rx_two_low_power_trip,
  input wire logic                      fault_out,
  input wire logic                      rx_signal_loss_out
);
  int         up_r;
  logic [1:0] last_sel_r;
  logic       seen_r;
  logic       fault_cause;
  logic       loss_cause;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  assign fault_cause = |(fault_enable & ~fault_mask & ch_flags);
  assign loss_cause = (rx_one_low_power_trip & loss_enable[0])
                    | (rx_two_low_power_trip & loss_enable[1]);
  // Cycles since reset release, saturating past the init delay
  always_ff @(posedge clk) begin
    if (!rst_b)
      up_r <= 0;
    else if (up_r < INIT_CNT + 8)
      up_r <= up_r + 1;
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      seen_r <= 1'b0;
      last_sel_r <= 2'h0;
    end else if (adc_start) begin
      seen_r <= 1'b1;
      last_sel_r <= adc_select;
    end
  end
  AST_OE_EARLY: assert property (
    up_r + 1 < INIT_CNT |-> !delta_sigma_out_one_oe && !delta_sigma_out_two_oe)
    else $error("outputs driven before init delay");
  AST_OE_LATE: assert property (
    up_r == INIT_CNT + 8 |-> delta_sigma_out_one_oe && delta_sigma_out_two_oe)
    else $error("outputs not driven after init delay");
  AST_RR_FIRST: assert property (
    adc_start && !seen_r |-> adc_select == CH_TEMP)
    else $error("first conversion is not temperature");
  AST_RR_NEXT: assert property (
    adc_start && seen_r |-> adc_select == 2'(last_sel_r + 2'h1))
    else $error("channel order broken");
  AST_START_PULSE: assert property (
    adc_start |=> !adc_start [*4])
    else $error("start pulse too long");
  AST_RESULT_CAUSE: assert property (
    !$stable(ch_result) || !$stable(ch_flags) |-> $past(adc_done))
    else $error("result or flags moved without conversion");
  AST_QT_PACE: assert property (
    !$stable(quick_trip_sel) |=> $stable(quick_trip_sel) [*6])
    else $error("comparator select toggles too fast");
  AST_TRIP_ONE: assert property (
    !$stable(rx_one_low_power_trip) |-> quick_trip_sel)
    else $error("receiver one trip moved off its sample");
  AST_TRIP_TWO: assert property (
    !$stable(rx_two_low_power_trip) |-> !quick_trip_sel)
    else $error("receiver two trip moved off its sample");
  AST_FAULT_GATE: assert property (
    !fault_cause |=> !fault_out)
    else $error("fault without enabled unmasked flag");
  AST_FAULT_SET: assert property (
    fault_cause && up_r == INIT_CNT + 8 |=> fault_out)
    else $error("fault missing");
  AST_LOSS_GATE: assert property (
    !loss_cause |=> !rx_signal_loss_out)
    else $error("loss output without enabled trip");
  AST_LOSS_SET: assert property (
    loss_cause && up_r == INIT_CNT + 8 |=> rx_signal_loss_out)
    else $error("loss output missing");
endmodule
bind transceiver_monitor_alarm monitor_alarm_checker #(.INIT_CNT(INIT_CNT)) chk_i (
  .clk, .rst_b, .adc_select, .adc_start, .adc_done, .ch_result, .ch_flags,
  .fault_enable, .fault_mask, .quick_trip_sel, .loss_enable,
  .delta_sigma_out_one_oe, .delta_sigma_out_two_oe, .rx_one_low_power_trip,
  .rx_two_low_power_trip, .fault_out, .rx_signal_loss_out);

//--- adc_qt_model.sv
// Converter and comparator stand-in facing the monitor block
`timescale 1ns/100ps
module adc_qt_model
  import monitor_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic [1:0]              adc_select,
  input  wire logic                    adc_start,
  input  wire logic [NUM_CH*RES_W-1:0] raw_in,
  input  wire logic                    slow,
  input  wire logic [1:0]              rx_low,
  input  wire logic                    quick_trip_sel,
  output logic                         adc_done,
  output logic [RES_W-1:0]             adc_raw,
  output logic                         quick_trip_cmp
);
  int               wait_r = 0;
  logic [1:0]       ch_r = 2'h0;
  logic [RES_W-1:0] last_r = 16'h0000;
  initial adc_done = 1'b0;
  // Outside the done cycle the data shows the inverse of the last code
  assign adc_raw = adc_done ? raw_in[ch_r*RES_W +: RES_W] : ~last_r;
  assign quick_trip_cmp = quick_trip_sel ? rx_low[1] : rx_low[0];
  always @(posedge clk) begin
    adc_done <= 1'b0;
    if (adc_start) begin
      ch_r <= adc_select;
      wait_r <= slow ? 6 : 2;
    end else if (wait_r == 1) begin
      adc_done <= 1'b1;
      wait_r <= 0;
    end else if (wait_r > 1)
      wait_r <= wait_r - 1;
    if (adc_done)
      last_r <= adc_raw;
  end
endmodule

//--- transceiver_monitor_alarm_tb_top.sv
// Self-checking bench for the monitor and alarm block
`timescale 1ns/100ps
module transceiver_monitor_alarm_tb_top
  import monitor_pkg::*;
;
  localparam int PASS = 2 * NUM_CH * 16 + 8;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] adc_select, loss_enable = 2'b00, rx_low = 2'b00;
  logic adc_start, adc_done, quick_trip_cmp, quick_trip_sel, slow = 1'b0;
  logic [RES_W-1:0] adc_raw, supply_scale = 16'h8000;
  logic [NUM_CH*RES_W-1:0] ch_result, ch_offset = 64'h0010;
  logic [NUM_CH*RES_W-1:0] raw_in = 64'h2000_0100;
  logic [2*RES_W-1:0] rx_scale = 32'h8000_8000;
  logic [SHIFT_W-1:0] rx_one_shift = 3'h0, rx_two_shift = 3'h0;
  limits_s [NUM_CH-1:0] ch_limits = {64'hFFFF_FFFF_0000_0000,
    64'h1000_0800_0100_0080, 64'hFFFF_FFFF_3000_3000, 64'hFFFF_FFFF_0000_0000};
  flags_s [NUM_CH-1:0] fault_enable = 16'h0400, fault_mask = 16'h0000, ch_flags;
  logic supply_low_enable = 1'b1;
  logic [2*CODE_W-1:0] init_code = 20'h0A5C3, table_code = 20'h3C1E7;
  logic [2*CODE_W-1:0] delta_sigma_code;
  logic delta_sigma_out_one_oe, delta_sigma_out_two_oe, fault_out;
  logic rx_one_low_power_trip, rx_two_low_power_trip, rx_signal_loss_out;
  int bad_count = 0;
  int n_checks = 0;
  always #20 clk = ~clk;
  transceiver_monitor_alarm #(.INIT_CNT(20), .SLOT_CNT(16), .QT_CNT(8)) uut (
    .clk, .rst_b, .adc_select, .adc_start, .adc_done, .adc_raw, .ch_offset,
    .rx_scale, .supply_scale, .rx_one_shift, .rx_two_shift, .ch_limits,
    .fault_enable, .fault_mask, .supply_low_enable, .quick_trip_cmp,
    .quick_trip_sel, .loss_enable, .init_code, .table_code,
    .delta_sigma_code, .delta_sigma_out_one_oe, .delta_sigma_out_two_oe,
    .ch_result, .ch_flags, .rx_one_low_power_trip, .rx_two_low_power_trip,
    .fault_out, .rx_signal_loss_out);
  adc_qt_model far_i (.clk, .adc_select, .adc_start, .raw_in, .slow, .rx_low,
    .quick_trip_sel, .adc_done, .adc_raw, .quick_trip_cmp);
  // ----------------------------------------------------------------
  // Common tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic conclude();
    if (bad_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_power();
    cyc(4);
    #1 chk({delta_sigma_out_one_oe, delta_sigma_out_two_oe}, 20'h0);
    cyc(24);
    #1 chk({delta_sigma_out_one_oe, delta_sigma_out_two_oe}, 20'h3);
    chk(delta_sigma_code, init_code);
    @(posedge clk);
    raw_in[31:16] <= 16'h8000;
    cyc(PASS);
    #1 chk(delta_sigma_code, table_code);
  endtask
  task automatic t_results();
    @(posedge clk);
    raw_in[31:0] <= 32'hFFFF_7FFF;
    supply_scale <= 16'hFFFF;
    cyc(PASS);
    #1 chk(ch_result[15:0], 20'h800F);
    chk(ch_result[31:16], UNSIGNED_MAX);
  endtask
  task automatic t_shift();
    for (int n = 0; n < 8; n++) begin
      @(posedge clk);
      rx_one_shift <= n[2:0];
      rx_two_shift <= 3'(7 - n);
      slow <= n[0];
      raw_in[63:32] <= 32'h8000_F000;
      cyc(PASS);
      #1 chk(ch_result[47:32], 16'h7800 >> n);
      chk(ch_result[63:48], 16'h4000 >> (7 - n));
    end
  endtask
  task automatic t_flags();
    @(posedge clk);
    rx_one_shift <= 3'h0;
    raw_in[47:32] <= 16'h1800;
    cyc(PASS);
    #1 chk(ch_flags[2], 20'h4);
    chk(fault_out, 20'h1);
    @(posedge clk);
    fault_mask <= 16'h0400;
    cyc(PASS);
    #1 chk({ch_flags[2], fault_out}, 20'h8);
    @(posedge clk);
    fault_mask <= 16'h0000;
    raw_in[47:32] <= 16'h0080;
    cyc(PASS);
    #1 chk({ch_flags[2], fault_out}, 20'h6);
  endtask
  task automatic t_quick();
    @(posedge clk);
    rx_low <= 2'b01;
    loss_enable <= 2'b01;
    cyc(40);
    #1 chk({rx_one_low_power_trip, rx_two_low_power_trip,
            rx_signal_loss_out}, 20'h5);
    @(posedge clk);
    rx_low <= 2'b10;
    cyc(40);
    #1 chk({rx_one_low_power_trip, rx_two_low_power_trip,
            rx_signal_loss_out}, 20'h2);
    @(posedge clk);
    loss_enable <= 2'b10;
    cyc(40);
    #1 chk(rx_signal_loss_out, 20'h1);
  endtask
  task automatic t_supply();
    @(posedge clk);
    raw_in[31:16] <= 16'h2000;
    cyc(PASS);
    #1 chk(delta_sigma_code, init_code);
    @(posedge clk);
    supply_low_enable <= 1'b0;
    cyc(2);
    #1 chk(delta_sigma_code, table_code);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_power();
    t_results();
    t_shift();
    t_flags();
    t_quick();
    t_supply();
    conclude();
  end
  initial begin
    cyc(20000);
    bad_count++;
    conclude();
  end
endmodule
